// [design/tlr_cfg.svh]
// Register offsets, field positions and reset values of the trigger line block
`ifndef TLR_CFG_SVH
`define TLR_CFG_SVH
`define TLR_AW 4
`define TLR_DW 16
`define TLR_NLINE 4
`define TLR_OFF_OUT_CTRL 4'h0
`define TLR_OFF_RECOG_CTRL 4'h1
`define TLR_OFF_PIN_FUNC 4'h2
`define TLR_OFF_REQ_STAT 4'h3
`define TLR_OFF_REQ_MASK 4'h4
`define TLR_OFF_LINE_LVL 4'h5
`define TLR_RST_REG 16'h0000
`define TLR_OUT_LVL_LSB 0
`define TLR_OUT_DIR_LSB 8
`define TLR_L0_FLAGS_LSB 0
`define TLR_L0_SYNC_BIT 4
`define TLR_L0_MASK_BIT 5
`define TLR_L0_COND_LSB 6
`define TLR_L1_FLAGS_LSB 8
`define TLR_L1_SYNC_BIT 12
`define TLR_L1_MASK_BIT 13
`define TLR_L1_COND_LSB 14
`define TLR_EVT_OFF_BIT 7
`define TLR_FLAG_SUSPEND 0
`define TLR_FLAG_END 1
`define TLR_FLAG_RESUME 2
`define TLR_FLAG_BEGIN 3
`define TLR_COND_FALL 2'h0
`define TLR_COND_RISE 2'h1
`define TLR_COND_CNT0 2'h2
`define TLR_COND_CNT1 2'h3
`define TLR_PAT_HL 2'h0
`define TLR_PAT_LH 2'h1
`define TLR_PAT_LL 2'h2
`define TLR_PAT_HH 2'h3
`endif

// [design/tlr_pkg.sv]
// Types shared by the trigger line block
package tlr_pkg;
    typedef enum logic [3:0] {
        TLR_RESET_IDLE_T, TLR_RUN_IDLE, TLR_SEL_DR, TLR_CAP_DR, TLR_SHIFT_DR, TLR_EXIT1_DR,
        TLR_PAUSE_DR, TLR_EXIT2_DR, TLR_UPD_DR, TLR_SEL_IR, TLR_CAP_IR, TLR_SHIFT_IR,
        TLR_EXIT1_IR, TLR_PAUSE_IR, TLR_EXIT2_IR, TLR_UPD_IR
    } tlr_scan_state_t;
endpackage

// [design/tlr_recog.sv]
// Event recognition for one trigger line
`timescale 1ns/1ns
`include "tlr_cfg.svh"
module tlr_recog (
    input wire logic clk,
    input wire logic reset,
    input wire logic line_lvl,
    input wire logic tck_rise,
    input wire logic sync_mode,
    input wire logic [1:0] cond,
    input wire logic masked,
    input wire logic is_output,
    input wire logic cnt0_zero,
    input wire logic cnt1_zero,
    output logic event_pulse
);
    logic prev_r;
    logic samp_cur_r;
    logic samp_cnt_r;
    logic async_hit;
    logic sync_hit;
    logic pat_ok;

    always_ff @(posedge clk)
    begin
        if (reset)
            prev_r <= 1'b0;
        else
            prev_r <= line_lvl;
    end

    // Two test-clock samples; a fresh pair needs two edges after a mode change
    always_ff @(posedge clk)
    begin
        if (reset || !sync_mode)
        begin
            samp_cur_r <= 1'b0;
            samp_cnt_r <= 1'b0;
        end
        else if (tck_rise)
        begin
            samp_cur_r <= line_lvl;
            samp_cnt_r <= 1'b1;
        end
    end

    always_comb
    begin
        async_hit = 1'b0;
        // [R10] Edge conditions
        // [R11] Counter zero crossing
        unique case (cond)
            `TLR_COND_FALL: async_hit = prev_r && !line_lvl;
            `TLR_COND_RISE: async_hit = !prev_r && line_lvl;
            `TLR_COND_CNT0: async_hit = cnt0_zero;
            `TLR_COND_CNT1: async_hit = cnt1_zero;
        endcase
        pat_ok = 1'b0;
        // [R12] Two-sample level patterns
        unique case (cond)
            `TLR_PAT_HL: pat_ok = samp_cur_r && !line_lvl;
            `TLR_PAT_LH: pat_ok = !samp_cur_r && line_lvl;
            `TLR_PAT_LL: pat_ok = !samp_cur_r && !line_lvl;
            `TLR_PAT_HH: pat_ok = samp_cur_r && line_lvl;
        endcase
        sync_hit = tck_rise && samp_cnt_r && pat_ok;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            event_pulse <= 1'b0;
        else
            // [R17] Outputs never trigger
            event_pulse <= !masked && !is_output && (sync_mode ? sync_hit : async_hit);
    end
endmodule

// [design/tlr_top.sv]
// Trigger line output control, recognition and request flags
// Function
// [R1] Output lines drive the level from output control bits 0 to 3.
// [R2] Output control bits 8 to 11 make lines 0 to 3 outputs when one.
// [R3] Recognition bit 0 lets line 0 set the suspend request.
// [R4] Recognition bit 1 lets line 0 set the end request.
// [R5] Recognition bit 2 lets line 0 set the resume request.
// [R6] Recognition bit 3 lets line 0 set the begin request.
// [R7] Bits 8 to 11 let line 1 set suspend, end, resume, begin.
// [R8] Bit 4 picks asynchronous or test-clock synchronous recognition of line 0.
// [R9] Bit 5 masks line 0 during capture, shift, exit and pause states.
// [R10] Asynchronous codes 00 and 01 pick falling or rising edge.
// [R11] Asynchronous codes 10 and 11 pick first or second counter zero crossing.
// [R12] Synchronous codes pick patterns high-low, low-high, low-low, high-high.
// [R13] Bit 12 picks asynchronous or synchronous recognition of line 1.
// [R14] Bit 13 masks line 1 during capture, shift, exit and pause states.
// [R15] Bits 15:14 pick line 1 condition with the line 0 codes.
// [R16] Global switch bit 7 turns off every trigger line output driver.
// [R17] Flags stay set until consumed; output lines raise no events.
`timescale 1ns/1ns
`include "tlr_cfg.svh"
module tlr_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [`TLR_AW-1:0] reg_addr,
    input wire logic [`TLR_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`TLR_DW-1:0] reg_rdata,
    input wire logic [`TLR_NLINE-1:0] trig_in,
    output logic [`TLR_NLINE-1:0] trig_out,
    output logic [`TLR_NLINE-1:0] trig_oe_n,
    input wire logic test_clk,
    input wire tlr_pkg::tlr_scan_state_t scan_state,
    input wire logic cnt0_zero,
    input wire logic cnt1_zero,
    input wire logic [3:0] req_consume,
    output logic [3:0] req_flags,
    output logic irq
);
    logic [`TLR_DW-1:0] out_ctrl_r;
    logic [`TLR_DW-1:0] recog_ctrl_r;
    logic [`TLR_DW-1:0] pin_func_r;
    logic [3:0] req_mask_r;
    logic [3:0] req_nxt;
    logic [`TLR_NLINE-1:0] trig_meta_r;
    logic [`TLR_NLINE-1:0] trig_sync_r;
    logic tck_meta_r;
    logic tck_sync_r;
    logic tck_prev_r;
    logic tck_rise;
    logic in_scan_window;
    logic evt0;
    logic evt1;
    logic [3:0] set0;
    logic [3:0] set1;
    logic [3:0] w1c;
    logic [3:0] mask_nxt;

    // States where a masked line is ignored
    function automatic logic scan_busy(input tlr_pkg::tlr_scan_state_t st);
        unique case (st)
            tlr_pkg::TLR_CAP_DR, tlr_pkg::TLR_SHIFT_DR, tlr_pkg::TLR_EXIT1_DR,
            tlr_pkg::TLR_PAUSE_DR, tlr_pkg::TLR_EXIT2_DR,
            tlr_pkg::TLR_CAP_IR, tlr_pkg::TLR_SHIFT_IR, tlr_pkg::TLR_EXIT1_IR,
            tlr_pkg::TLR_PAUSE_IR, tlr_pkg::TLR_EXIT2_IR: scan_busy = 1'b1;
            default: scan_busy = 1'b0;
        endcase
    endfunction

    // Pins and test clock are asynchronous
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            trig_meta_r <= '0;
            trig_sync_r <= '0;
            tck_meta_r <= 1'b0;
            tck_sync_r <= 1'b0;
            tck_prev_r <= 1'b0;
        end
        else
        begin
            trig_meta_r <= trig_in;
            trig_sync_r <= trig_meta_r;
            tck_meta_r <= test_clk;
            tck_sync_r <= tck_meta_r;
            tck_prev_r <= tck_sync_r;
        end
    end

    // Test clock must stay well below half the system clock rate
    assign tck_rise = tck_sync_r && !tck_prev_r;
    assign in_scan_window = scan_busy(scan_state);

    // Control registers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            out_ctrl_r <= `TLR_RST_REG;
            recog_ctrl_r <= `TLR_RST_REG;
            pin_func_r <= `TLR_RST_REG;
            req_mask_r <= 4'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `TLR_OFF_OUT_CTRL)
                out_ctrl_r <= reg_wdata;
            if (reg_addr == `TLR_OFF_RECOG_CTRL)
                recog_ctrl_r <= reg_wdata;
            if (reg_addr == `TLR_OFF_PIN_FUNC)
                pin_func_r <= reg_wdata;
            if (reg_addr == `TLR_OFF_REQ_MASK)
                req_mask_r <= reg_wdata[3:0];
        end
    end

    // Pin drivers
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            trig_out <= '0;
            trig_oe_n <= '1;
        end
        else
        begin
            // [R1] Output levels
            trig_out <= out_ctrl_r[`TLR_OUT_LVL_LSB +: `TLR_NLINE];
            // [R2] Direction bits
            // [R16] Global driver off
            trig_oe_n <= ~out_ctrl_r[`TLR_OUT_DIR_LSB +: `TLR_NLINE]
                | {`TLR_NLINE{pin_func_r[`TLR_EVT_OFF_BIT]}};
        end
    end

    // [R8] Line 0 mode select
    // [R9] Line 0 scan masking
    tlr_recog u_recog0 (
        .clk(clk),
        .reset(reset),
        .line_lvl(trig_sync_r[0]),
        .tck_rise(tck_rise),
        .sync_mode(recog_ctrl_r[`TLR_L0_SYNC_BIT]),
        .cond(recog_ctrl_r[`TLR_L0_COND_LSB +: 2]),
        .masked(recog_ctrl_r[`TLR_L0_MASK_BIT] && in_scan_window),
        .is_output(out_ctrl_r[`TLR_OUT_DIR_LSB]),
        .cnt0_zero(cnt0_zero),
        .cnt1_zero(cnt1_zero),
        .event_pulse(evt0)
    );

    // [R13] Line 1 mode select
    // [R14] Line 1 scan masking
    // [R15] Line 1 condition field
    tlr_recog u_recog1 (
        .clk(clk),
        .reset(reset),
        .line_lvl(trig_sync_r[1]),
        .tck_rise(tck_rise),
        .sync_mode(recog_ctrl_r[`TLR_L1_SYNC_BIT]),
        .cond(recog_ctrl_r[`TLR_L1_COND_LSB +: 2]),
        .masked(recog_ctrl_r[`TLR_L1_MASK_BIT] && in_scan_window),
        .is_output(out_ctrl_r[`TLR_OUT_DIR_LSB + 1]),
        .cnt0_zero(cnt0_zero),
        .cnt1_zero(cnt1_zero),
        .event_pulse(evt1)
    );

    always_comb
    begin
        // [R3] Line 0 suspend enable
        set0[`TLR_FLAG_SUSPEND] = evt0 && recog_ctrl_r[`TLR_L0_FLAGS_LSB + `TLR_FLAG_SUSPEND];
        // [R4] Line 0 end enable
        set0[`TLR_FLAG_END] = evt0 && recog_ctrl_r[`TLR_L0_FLAGS_LSB + `TLR_FLAG_END];
        // [R5] Line 0 resume enable
        set0[`TLR_FLAG_RESUME] = evt0 && recog_ctrl_r[`TLR_L0_FLAGS_LSB + `TLR_FLAG_RESUME];
        // [R6] Line 0 begin enable
        set0[`TLR_FLAG_BEGIN] = evt0 && recog_ctrl_r[`TLR_L0_FLAGS_LSB + `TLR_FLAG_BEGIN];
        // [R7] Line 1 flag enables
        set1 = {4{evt1}} & recog_ctrl_r[`TLR_L1_FLAGS_LSB +: 4];
        w1c = (reg_wr && reg_addr == `TLR_OFF_REQ_STAT) ? reg_wdata[3:0] : 4'h0;
        // New mask applies at once, no stale interrupt cycle
        mask_nxt = (reg_wr && reg_addr == `TLR_OFF_REQ_MASK) ? reg_wdata[3:0] : req_mask_r;
        // [R17] Sticky until consumed; a new event beats the clear
        req_nxt = (req_flags & ~(w1c | req_consume)) | set0 | set1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            req_flags <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            req_flags <= req_nxt;
            irq <= |(req_nxt & mask_nxt);
        end
    end

    // Read port, unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `TLR_OFF_OUT_CTRL: reg_rdata <= out_ctrl_r;
                `TLR_OFF_RECOG_CTRL: reg_rdata <= recog_ctrl_r;
                `TLR_OFF_PIN_FUNC: reg_rdata <= pin_func_r;
                `TLR_OFF_REQ_STAT: reg_rdata <= {12'h000, req_flags};
                `TLR_OFF_REQ_MASK: reg_rdata <= {12'h000, req_mask_r};
                `TLR_OFF_LINE_LVL: reg_rdata <= {12'h000, trig_sync_r};
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end
endmodule

// [verification/tlr_top_asserts.sv]
// Port checker of the trigger line block
`timescale 1ns/1ns
module tlr_top_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [3:0] trig_in,
    input wire logic [3:0] trig_out,
    input wire logic [3:0] trig_oe_n,
    input wire logic test_clk,
    input wire tlr_pkg::tlr_scan_state_t scan_state,
    input wire logic cnt0_zero,
    input wire logic cnt1_zero,
    input wire logic [3:0] req_consume,
    input wire logic [3:0] req_flags,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence out_wr_s;
        reg_wr && reg_addr == 4'h0;
    endsequence
    sequence rd_flag_s;
        reg_rd && reg_addr == 4'h3;
    endsequence
    out_level_a: assert property (out_wr_s |-> ##2
        (({12'h0, trig_out} ^ $past(reg_wdata, 2)) & {12'h0, ~trig_oe_n}) == 16'h0) else $error("out level");
    out_hold_a: assert property ($changed(trig_out) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == 4'h0) else $error("out change");
    out_dir_a: assert property (out_wr_s |-> ##2
        ({4'h0, ~trig_oe_n, 8'h0} & ~$past(reg_wdata, 2) & 16'h0f00) == 16'h0) else $error("out dir");
    rst_state_a: assert property ($past(reset) |->
        trig_oe_n == 4'hf && req_flags == 4'h0 && !irq) else $error("reset state");
    glob_off_a: assert property (reg_wr && reg_addr == 4'h2 && reg_wdata[7] |->
        ##2 trig_oe_n == 4'hf) else $error("global off");
    flag_hold_a: assert property (|($past(req_flags) & ~req_flags) |->
        $past(req_consume) != 4'h0 || $past(reg_wr) && $past(reg_addr) == 4'h3) else $error("flag drop");
    irq_cause_a: assert property (irq |-> req_flags != 4'h0) else $error("irq cause");
    rd_flags_a: assert property (rd_flag_s |=>
        reg_rdata == {12'h000, $past(req_flags)}) else $error("flag read");
endmodule
bind tlr_top tlr_top_chk chk (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in), .trig_out(trig_out),
    .trig_oe_n(trig_oe_n), .test_clk(test_clk), .scan_state(scan_state), .cnt0_zero(cnt0_zero),
    .cnt1_zero(cnt1_zero), .req_consume(req_consume), .req_flags(req_flags), .irq(irq));

// [verification/tlr_top_test.sv]
// Self-checking bench of the trigger line block
`timescale 1ns/1ns
module tlr_top_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic test_clk = 1'b0;
    logic cnt0_zero = 1'b0;
    logic cnt1_zero = 1'b0;
    logic irq;
    logic [3:0] reg_addr = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic [3:0] req_consume = 4'h0;
    logic [3:0] trig_in, trig_out, trig_oe_n, req_flags;
    logic [15:0] reg_wdata = 16'h0;
    logic [15:0] reg_rdata;
    logic [15:0] rv;
    logic [15:0] exp_q[$];
    tlr_pkg::tlr_scan_state_t scan_state = tlr_pkg::TLR_RUN_IDLE;
    integer seed = 32'h89702c27;
    int num_errors = 0;
    int compares = 0;
    always #2 clk = ~clk;
    tlr_top dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in), .trig_out(trig_out), .trig_oe_n(trig_oe_n),
        .test_clk(test_clk), .scan_state(scan_state), .cnt0_zero(cnt0_zero), .cnt1_zero(cnt1_zero),
        .req_consume(req_consume), .req_flags(req_flags), .irq(irq));
    tlr_wiring board (.trig_out(trig_out), .trig_oe_n(trig_oe_n), .lvl(lvl), .trig_in(trig_in));
    task report_and_stop;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check_rd(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask
    task check_pin(input string what, input logic [3:0] e, input logic [3:0] g);
        check_rd(what, {12'h0, e}, {12'h0, g});
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task cnt_pulse(input logic z0, input logic z1);
        @(posedge clk);
        cnt0_zero <= z0;
        cnt1_zero <= z1;
        @(posedge clk);
        cnt0_zero <= 1'b0;
        cnt1_zero <= 1'b0;
        tick(4);
    endtask
    task tck_pulse;
        @(posedge clk);
        test_clk <= 1'b1;
        tick(6);
        test_clk <= 1'b0;
        tick(6);
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
            check_rd("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
    initial
    begin
        tick(8);
        reset <= 1'b0;
        for (int a = 0; a < 7; a++)
            rd((a == 6) ? 4'hf : a[3:0], 16'h0);
        for (int i = 0; i < 4; i++)
        begin
            rv = 16'($random(seed)) & 16'h0f0f;
            wr(4'h0, rv);
            tick(2);
            check_pin("trig_oe_n", ~rv[11:8], trig_oe_n);
            check_pin("trig_out", rv[3:0] & rv[11:8], trig_out & rv[11:8]);
            rd(4'h0, rv);
            wr(4'h2, 16'h0080);
            tick(2);
            check_pin("trig_oe_n", 4'hf, trig_oe_n);
            wr(4'h2, 16'h0);
        end
        // Output line toggling itself must not raise a request
        wr(4'h1, 16'h0041);
        wr(4'h0, 16'h0100);
        wr(4'h0, 16'h0101);
        tick(8);
        rd(4'h3, 16'h0);
        wr(4'h0, 16'h0);
        wr(4'h4, 16'h000f);
        tick(2);
        for (int l = 0; l < 2; l++)
            for (int f = 0; f < 4; f++)
                for (int c = 0; c < 2; c++)
                begin
                    // Configure first, so the setup level moves against the chosen edge
                    wr(4'h1, 16'(((1 << f) | (c << 6)) << (8 * l)));
                    lvl[l] <= ~c[0];
                    tick(6);
                    lvl[l] <= c[0];
                    tick(8);
                    check_pin("irq", 4'h1, {3'h0, irq});
                    check_pin("req_flags", 4'(1 << f), req_flags);
                    rd(4'h3, 16'h1 << f);
                    wr(4'h3, 16'h000f);
                    lvl[l] <= ~c[0];
                    tick(8);
                    rd(4'h3, 16'h0);
                    check_pin("irq", 4'h0, {3'h0, irq});
                end
        for (int l = 0; l < 2; l++)
            for (int c = 0; c < 2; c++)
            begin
                wr(4'h1, 16'((((c + 2) << 6) | 1) << (8 * l)));
                cnt_pulse(c[0], ~c[0]);
                rd(4'h3, 16'h0);
                cnt_pulse(~c[0], c[0]);
                rd(4'h3, 16'h1);
                wr(4'h3, 16'h000f);
            end
        wr(4'h4, 16'h0);
        for (int l = 0; l < 2; l++)
        begin
            wr(4'h1, 16'(16'h0062 << (8 * l)));
            rv = 16'($random(seed));
            scan_state <= tlr_pkg::tlr_scan_state_t'(4'(3 + rv % 5 + 7 * l));
            lvl[l] <= 1'b1;
            tick(8);
            rd(4'h3, 16'h0);
            rd(4'h5, 16'(1 << l));
            scan_state <= tlr_pkg::TLR_RUN_IDLE;
            lvl[l] <= 1'b0;
            tick(8);
            lvl[l] <= 1'b1;
            tick(8);
            rd(4'h3, 16'h2);
            check_pin("irq", 4'h0, {3'h0, irq});
            wr(4'h3, 16'h000f);
            lvl[l] <= 1'b0;
        end
        for (int l = 0; l < 2; l++)
            for (int p = 0; p < 4; p++)
            begin
                wr(4'h1, 16'(((p << 6) | 16'h14) << (8 * l)));
                lvl[l] <= ~(p[0] ^ p[1]);
                tck_pulse;
                lvl[l] <= p[0];
                tck_pulse;
                rd(4'h3, 16'h4);
                @(posedge clk);
                req_consume <= 4'h4;
                @(posedge clk);
                req_consume <= 4'h0;
                lvl[l] <= ~p[0];
                tck_pulse;
                rd(4'h3, 16'h0);
            end
        // Mid-run reset puts both lines back to asynchronous recognition
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        rd(4'h1, 16'h0);
        rd(4'h3, 16'h0);
        tick(4);
        report_and_stop;
    end
endmodule

// [verification/tlr_wiring.sv]
// Board wiring model of the trigger lines
`timescale 1ns/1ns
module tlr_wiring (
    input wire logic [3:0] trig_out,
    input wire logic [3:0] trig_oe_n,
    input wire logic [3:0] lvl,
    output logic [3:0] trig_in
);
    assign trig_in = (trig_out & ~trig_oe_n) | (lvl & trig_oe_n);
endmodule
